// ### rtl/flash_cmd_front.sv
// Command front end of a serial flash: pause, opcode decode, status.
// Assumes link pins are asynchronous to ref_clk, which samples them.
//
// Contract
// - Pause low while selected suspends all serial communication.
// - Pause never stops a running program, erase or status write.
// - Pause starts on pause low only while selected and clock low.
// - Pause ends on pause high once the serial clock is low.
// - While paused, output is tristated and data and clock ignored.
// - Deselect during pause resets the interface logic.
// - Opcode 06 alone sets the write enable latch.
// - Opcode 04 alone clears the write enable latch.
// - Opcode 05 shifts out the eight status bits.
// - Status readable anytime, repeated while host keeps clocking.
// - Opcode 90, two dummy bytes, one address, then both identifiers.
// - Address zero gives maker id first, one gives part id first.
// - Program, erase, status write refused unless latch is set.
// - Latch clears at reset and after disable, write, program, erase.
// - Status bit 0 reads one while an internal cycle runs.
// - Block-protect bits change only by status write, block protected writes.
// - Chip erase runs only when both protect bits are zero.
// - Disable bit set and protect pin low blocks status writes.
// - Protect codes: none, block 3, blocks 2-3, whole array.
// - Input sampled on clock rise, output changed on clock fall.
// - Write-type commands need select to rise on a byte boundary.
// - Reset sets both protect bits and clears the disable bit.
`timescale 1ns/1ns
module flash_cmd_front
    import flash_cmd_pkg::*;
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    // Serial output, three-signal form
    output logic so_out,
    output logic so_oe,
    // Observed state
    output logic [7:0] device_status,
    output logic paused
);
    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_SKIP,
        ST_ID_ADDR,
        ST_ADDR,
        ST_STREAM,
        ST_WRITE_DATA,
        ST_IGNORE
    } phase_t;

    typedef struct packed {
        logic [2:0] sync_sclk;
        logic [2:0] sync_cs;
        logic [1:0] sync_si;
        logic [2:0] sync_hold;
        logic [1:0] sync_wp;
        logic hold;
        phase_t phase;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] opcode;
        logic [7:0] status_data;
        logic [23:0] addr;
        logic write_enable_latch;
        logic [1:0] bp;
        logic status_write_disable;
        logic busy;
        logic [15:0] busy_cnt;
        logic [7:0] out_byte;
        logic [2:0] out_bit;
        logic out_loaded;
        logic id_toggle;
        logic so_out;
        logic so_oe;
        logic [7:0] status_q;
    } state_t;

    state_t q;
    state_t next_q;

    // FIFO handshake between decoder and shifter
    logic [7:0] fifo_in;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [7:0] fifo_out;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic fifo_flush;

    flash_fifo #(.WIDTH(8), .DEPTH(32)) u_out_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .flush(fifo_flush)
    );

    // Synchronised pin views (second and third stages only)
    logic sclk_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_s;
    logic cs_rise;
    logic si_s;
    logic hold_s;
    logic wp_s;
    logic [7:0] live_status;
    logic [7:0] new_byte;
    logic wr_allowed;
    logic bp_blocks;
    logic [1:0] target_block;

    assign sclk_s = q.sync_sclk[1];
    assign sclk_rise = q.sync_sclk[1] && !q.sync_sclk[2];
    assign sclk_fall = !q.sync_sclk[1] && q.sync_sclk[2];
    assign cs_s = q.sync_cs[1];
    assign cs_rise = q.sync_cs[1] && !q.sync_cs[2];
    assign si_s = q.sync_si[1];
    assign hold_s = q.sync_hold[1];
    assign wp_s = q.sync_wp[1];
    assign new_byte = {q.shift[6:0], si_s};
    assign live_status = {q.status_write_disable, 3'h0, q.bp, q.write_enable_latch, q.busy};
    // Write-type commands need the latch and an idle array
    assign wr_allowed = q.write_enable_latch && !q.busy;
    // Top blocks protected by code: 1 -> 3, 2 -> 2..3, 3 -> all
    assign target_block = q.addr[17:16];
    assign bp_blocks = (q.bp == 2'h3) ||
        (q.bp == 2'h2 && target_block[1]) ||
        (q.bp == 2'h1 && target_block == 2'h3);

    // Next-state logic
    always_comb
    begin
        next_q = q;
        fifo_in = 8'h00;
        fifo_in_valid = 1'b0;
        fifo_out_ready = 1'b0;
        fifo_flush = 1'b0;
        next_q.sync_sclk = {q.sync_sclk[1:0], sclk};
        next_q.sync_cs = {q.sync_cs[1:0], cs_n};
        next_q.sync_si = {q.sync_si[0], si};
        next_q.sync_hold = {q.sync_hold[1:0], hold_n};
        next_q.sync_wp = {q.sync_wp[0], wp_n};
        next_q.status_q = live_status;

        // Internal cycle runs regardless of pause or select
        if (q.busy)
        begin
            if (q.busy_cnt == 16'h0001)
            begin
                next_q.busy = 1'b0;
                next_q.write_enable_latch = 1'b0;
            end
            next_q.busy_cnt = q.busy_cnt - 16'h0001;
        end

        // Pause entry and exit only while clock is low
        if (!cs_s && !sclk_s)
            next_q.hold = !hold_s;

        if (cs_s)
        begin
            // Deselect: execute write-type commands on byte boundary
            if (cs_rise && q.phase != ST_IGNORE && !q.hold &&
                q.bit_cnt == 3'h0 && q.byte_cnt != 3'h0)
            begin
                case (q.opcode)
                    OP_WRITE_ENABLE: next_q.write_enable_latch = !q.busy;
                    OP_WRITE_DISABLE: next_q.write_enable_latch = 1'b0;
                    OP_STATUS_WRITE:
                        if (wr_allowed && q.byte_cnt == 3'h2 &&
                            !(q.status_write_disable && !wp_s))
                        begin
                            next_q.status_write_disable = q.status_data[STATUS_WRITE_DISABLE_BIT];
                            next_q.bp = q.status_data[BP_HI_BIT:BP_LO_BIT];
                            next_q.busy = 1'b1;
                            next_q.busy_cnt = BUSY_CYCLES;
                        end
                    OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
                        if (wr_allowed && q.bp == 2'h0)
                        begin
                            next_q.busy = 1'b1;
                            next_q.busy_cnt = BUSY_CYCLES;
                        end
                    OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE_A,
                    OP_BLOCK_ERASE_B:
                        if (wr_allowed && q.byte_cnt >= 3'h4 &&
                            !bp_blocks)
                        begin
                            next_q.busy = 1'b1;
                            next_q.busy_cnt = BUSY_CYCLES;
                        end
                    default: next_q.write_enable_latch = q.write_enable_latch;
                endcase
            end
            // Deselect also clears pause and interface state
            next_q.hold = 1'b0;
            next_q.phase = ST_OPCODE;
            next_q.bit_cnt = 3'h0;
            next_q.byte_cnt = 3'h0;
            next_q.out_loaded = 1'b0;
            next_q.so_oe = 1'b0;
            fifo_flush = 1'b1;
        end
        else if (q.hold)
        begin
            // Clock and data ignored, output released
            next_q.so_oe = 1'b0;
        end
        else
        begin
            if (q.out_loaded && !q.so_oe && q.phase == ST_STREAM)
                next_q.so_oe = 1'b1;
            // Sample input on clock rise
            if (sclk_rise)
            begin
                next_q.shift = new_byte;
                next_q.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == 3'h7)
                begin
                    if (q.byte_cnt != 3'h7)
                        next_q.byte_cnt = q.byte_cnt + 3'h1;
                    case (q.phase)
                        ST_OPCODE:
                        begin
                            next_q.opcode = new_byte;
                            case (new_byte)
                                OP_STATUS_READ: next_q.phase = ST_STREAM;
                                OP_MAKER_PART_ID: next_q.phase = ST_SKIP;
                                OP_STATUS_WRITE:
                                    next_q.phase = ST_WRITE_DATA;
                                OP_PAGE_PROGRAM, OP_SECTOR_ERASE,
                                OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B:
                                    next_q.phase = ST_ADDR;
                                OP_WRITE_ENABLE, OP_WRITE_DISABLE,
                                OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
                                    next_q.phase = ST_WRITE_DATA;
                                default: next_q.phase = ST_IGNORE;
                            endcase
                        end
                        ST_SKIP:
                            if (q.byte_cnt == ID_ADDR_BYTES - 3'h1)
                                next_q.phase = ST_ID_ADDR;
                        ST_ID_ADDR:
                        begin
                            next_q.id_toggle = new_byte[0];
                            next_q.phase = ST_STREAM;
                        end
                        ST_ADDR:
                            if (q.byte_cnt <= ID_ADDR_BYTES)
                                next_q.addr = {q.addr[15:0], new_byte};
                        ST_WRITE_DATA: next_q.status_data = new_byte;
                        ST_STREAM: next_q.phase = ST_STREAM;
                        ST_IGNORE: next_q.phase = ST_IGNORE;
                        default: next_q.phase = ST_IGNORE;
                    endcase
                end
            end
            // Refill only when empty, so polled status stays fresh
            if (q.phase == ST_STREAM && fifo_in_ready && !fifo_out_valid)
            begin
                fifo_in_valid = 1'b1;
                if (q.opcode == OP_STATUS_READ)
                    fifo_in = live_status;
                else
                begin
                    fifo_in = q.id_toggle ? PART_ID : MAKER_ID;
                    next_q.id_toggle = !q.id_toggle;
                end
            end
            // Shift out on clock fall
            if (q.phase == ST_STREAM && sclk_fall)
            begin
                if (!q.out_loaded || q.out_bit == 3'h0)
                begin
                    fifo_out_ready = 1'b1;
                    next_q.out_byte = fifo_out_valid ?
                        {fifo_out[6:0], 1'b0} : 8'h00;
                    next_q.so_out = fifo_out[7];
                    next_q.out_bit = 3'h7;
                    next_q.out_loaded = fifo_out_valid;
                    next_q.so_oe = 1'b1;
                end
                else
                begin
                    next_q.so_out = q.out_byte[7];
                    next_q.out_byte = {q.out_byte[6:0], 1'b0};
                    next_q.out_bit = q.out_bit - 3'h1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.sync_cs <= 3'h7;
            q.sync_hold <= 3'h7;
            q.sync_wp <= 2'h3;
            q.phase <= ST_OPCODE;
            q.bp <= BP_RESET;
            q.status_write_disable <= STATUS_WRITE_DISABLE_RESET;
            q.write_enable_latch <= 1'b0;
        end
        else
            q <= next_q;
    end

    assign so_out = q.so_out;
    assign so_oe = q.so_oe;
    assign device_status = q.status_q;
    assign paused = q.hold;

    chk_hold_tristate: assert property (@(posedge ref_clk) disable iff (rst)
        q.hold |=> !q.so_oe)
        else $error("output driven during pause");
    chk_hold_entry_low: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(q.hold) |-> $past(!sclk_s) && $past(!cs_s))
        else $error("pause entered with clock high");
    chk_hold_exit_low: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(q.hold) && $past(!cs_s) |-> $past(!sclk_s))
        else $error("pause left with clock high");
    chk_deselect_reset: assert property (@(posedge ref_clk) disable iff (rst)
        cs_s |=> !q.hold && q.phase == ST_OPCODE)
        else $error("deselect did not reset interface");
    chk_wel_set: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(q.write_enable_latch) |-> $past(q.opcode) == OP_WRITE_ENABLE)
        else $error("latch set without write enable");
    chk_busy_needs_wel: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(q.busy) |-> $past(q.write_enable_latch))
        else $error("write cycle started without latch");
    chk_busy_ends_wel: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(q.busy) |-> !q.write_enable_latch)
        else $error("latch not cleared after cycle");
    chk_chip_erase_bp: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(q.busy) && ($past(q.opcode) == OP_CHIP_ERASE_A ||
        $past(q.opcode) == OP_CHIP_ERASE_B) |-> $past(q.bp) == 2'h0)
        else $error("chip erase ran while protected");
    chk_status_locked: assert property (@(posedge ref_clk) disable iff (rst)
        $past(q.status_write_disable) && $past(!wp_s) && !$past(q.busy) |->
        $stable(q.bp))
        else $error("protected status changed");
    chk_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
        device_status[6:4] == 3'h0)
        else $error("unused status bits not zero");
    chk_busy_bit: assert property (@(posedge ref_clk) disable iff (rst)
        q.busy |=> device_status[WIP_BIT])
        else $error("busy bit not shown");
endmodule

// ### rtl/flash_cmd_pkg.sv
// Constants for the serial flash command front end.
// Assumes one system clock samples all link pins.
package flash_cmd_pkg;
    // Opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_MAKER_PART_ID = 8'h90;
    localparam logic [7:0] OP_IDENT_READ = 8'h9f;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE_A = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE_B = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    // Status field positions
    localparam int WIP_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam int BP_LO_BIT = 2;
    localparam int BP_HI_BIT = 3;
    localparam int STATUS_WRITE_DISABLE_BIT = 7;
    // Reset values of the volatile bits
    localparam logic [1:0] BP_RESET = 2'h3;
    localparam logic STATUS_WRITE_DISABLE_RESET = 1'b0;
    // Identifiers: arbitrary neutral values
    localparam logic [7:0] MAKER_ID = 8'h5a;
    localparam logic [7:0] PART_ID = 8'h11;
    // Busy time of an internal cycle, in system clocks
    localparam logic [15:0] BUSY_CYCLES = 16'h0040;
    // Address bytes of a command; id read skips all but the last before the selector
    localparam logic [2:0] ID_ADDR_BYTES = 3'h3;
    // Size of one of the four blocks of the 2 Mbit array
    localparam logic [17:0] BLOCK_SHIFT = 18'h10000;
endpackage

// ### rtl/flash_fifo.sv
// Byte FIFO between the command decoder and the output shifter.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ns
module flash_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Write side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Read side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // Flush
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    // Full when pointers differ only in wrap bit
    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and storage update
    always_ff @(posedge ref_clk)
    begin
        if (rst || flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr[AW-1:0]] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ### verification/spi_host_model.sv
// Host side model: drives the link pins of the flash front end except wp_n.
// Assumes mode 0 timing and eight ref_clk cycles per serial clock.
`timescale 1ns/1ns
module spi_host_model
(
    // Sampling clock
    input wire logic ref_clk,
    // Pins driven toward the device
    output logic sclk,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    // Serial output, three-signal form
    input wire logic so_out,
    input wire logic so_oe
);
    // Idle bus: deselected, clock parked low
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Data set while clock low, read back late in the high phase
    task automatic bits(input logic [7:0] tx, input int n,
        output logic [7:0] rx);
        rx = 8'hff;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            rx[i] = so_oe ? so_out : 1'b1; // Pull-up on released line
            sclk = 1'b0;
        end
    endtask
    // Resume only with pause released before select falls
    task automatic select();
        hold_n = 1'b1;
        tick(1);
        cs_n = 1'b0;
        tick(4);
    endtask
    // Select rises wherever the caller stopped, mid-byte too; data line left toggled
    task automatic deselect();
        tick(4);
        cs_n = 1'b1;
        si = ~si;
        tick(8);
    endtask
    // Raw pin moves for pause scenarios
    task automatic pins(input logic s, input logic h);
        sclk = s;
        hold_n = h;
        si = ~si;
        tick(6);
    endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the flash command front end.
// Assumes the host model drives every link pin of the front end except wp_n, which the bench drives.
`timescale 1ns/1ns
module tb import flash_cmd_pkg::*;;
    typedef logic [7:0] byte_q_t[$];
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic sclk;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so_out;
    logic so_oe;
    logic paused;
    logic [7:0] device_status;
    logic [7:0] rd;
    logic [7:0] rd2;
    int failures = 0;
    int cmp_count = 0;

    always #50 ref_clk = ~ref_clk;

    flash_cmd_front uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_out(so_out), .so_oe(so_oe), .device_status(device_status),
        .paused(paused));
    spi_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
        .si(si), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic flag(input logic b, input logic e);
        check({7'h0, b}, {7'h0, e});
    endtask
    task automatic test_done();
        $display("Compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One whole command, select rising on a byte boundary
    task automatic send(input byte_q_t q);
        host.select();
        foreach (q[i])
            host.bits(q[i], 8, rd);
        host.deselect();
    endtask
    task automatic read_status(output logic [7:0] s1, output logic [7:0] s2);
        host.select();
        host.bits(OP_STATUS_READ, 8, s1);
        host.bits(8'h00, 8, s1);
        host.bits(8'h00, 8, s2);
        host.deselect();
    endtask
    // Bounded wait; busy lasts 64 clocks
    task automatic wait_idle();
        for (int i = 0; i < 300 && device_status[WIP_BIT] !== 1'b0; i++)
            @(negedge ref_clk);
        flag(device_status[WIP_BIT], 1'b0);
    endtask
    task automatic write_status(input logic [7:0] v);
        send('{OP_WRITE_ENABLE});
        send('{OP_STATUS_WRITE, v});
        wait_idle();
    endtask

    task automatic t_reset();
        check(device_status, 8'h0c);
        flag(paused, 1'b0);
        flag(so_oe, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_latch();
        send('{OP_WRITE_ENABLE});
        read_status(rd, rd2);
        check(rd, 8'h0e);
        check(rd2, 8'h0e);
        send('{OP_WRITE_DISABLE});
        check(device_status, 8'h0c);
        host.select();
        host.bits(OP_WRITE_ENABLE, 8, rd);
        host.bits(8'h00, 1, rd);
        host.deselect();
        check(device_status, 8'h0c);
        $display("latch test done");
    endtask
    task automatic t_status_write();
        send('{OP_STATUS_WRITE, 8'h00});
        check(device_status, 8'h0c);
        send('{OP_WRITE_ENABLE});
        send('{OP_STATUS_WRITE, 8'hfc});
        flag(device_status[WIP_BIT], 1'b1);
        wait_idle();
        check(device_status, 8'h8c);
        wp_n = 1'b0;
        write_status(8'h00);
        check(device_status & 8'h8d, 8'h8c);
        send('{OP_WRITE_DISABLE});
        wp_n = 1'b1;
        write_status(8'h00);
        check(device_status, 8'h00);
        $display("status write test done");
    endtask
    task automatic t_protect();
        write_status(8'h04);
        check(device_status, 8'h04);
        send('{OP_WRITE_ENABLE});
        send('{OP_PAGE_PROGRAM, 8'h03, 8'h00, 8'h00, 8'h55});
        flag(device_status[WIP_BIT], 1'b0);
        send('{OP_SECTOR_ERASE, 8'h03, 8'h10, 8'h00});
        flag(device_status[WIP_BIT], 1'b0);
        send('{OP_BLOCK_ERASE_A, 8'h02, 8'h00, 8'h00});
        flag(device_status[WIP_BIT], 1'b1);
        wait_idle();
        send('{OP_WRITE_ENABLE});
        send('{OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h55});
        flag(device_status[WIP_BIT], 1'b1);
        wait_idle();
        check(device_status, 8'h04);
        send('{OP_WRITE_ENABLE});
        send('{OP_CHIP_ERASE_A});
        flag(device_status[WIP_BIT], 1'b0);
        send('{OP_WRITE_DISABLE});
        write_status(8'h00);
        for (int i = 0; i < 2; i++)
        begin
            send('{i == 0 ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B});
            flag(device_status[WIP_BIT], 1'b0);
            send('{OP_WRITE_ENABLE});
            send('{i == 0 ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B});
            flag(device_status[WIP_BIT], 1'b1);
            wait_idle();
            check(device_status, 8'h00);
        end
        $display("protect test done");
    endtask
    task automatic t_ident();
        for (int s = 0; s < 2; s++)
        begin
            host.select();
            host.bits(OP_MAKER_PART_ID, 8, rd);
            host.bits(8'h00, 8, rd);
            host.bits(8'h00, 8, rd);
            host.bits(8'(s), 8, rd);
            host.bits(8'h00, 8, rd);
            host.bits(8'h00, 8, rd2);
            host.deselect();
            check(rd, s == 1 ? PART_ID : MAKER_ID);
            check(rd2, s == 1 ? MAKER_ID : PART_ID);
        end
        $display("ident test done");
    endtask
    task automatic t_unknown();
        host.select();
        host.bits(8'hff, 8, rd);
        host.bits(OP_STATUS_READ, 8, rd);
        host.bits(8'h00, 8, rd);
        host.deselect();
        check(rd, 8'hff);
        $display("unknown opcode test done");
    endtask
    task automatic t_pause();
        send('{OP_WRITE_ENABLE});
        host.select();
        host.bits(OP_STATUS_READ, 8, rd);
        host.pins(1'b0, 1'b0);
        flag(paused, 1'b1);
        flag(so_oe, 1'b0);
        host.pins(1'b1, 1'b0);
        host.pins(1'b1, 1'b1);
        flag(paused, 1'b1);
        host.pins(1'b0, 1'b1);
        flag(paused, 1'b0);
        host.bits(8'h00, 8, rd);
        check(rd, 8'h02);
        host.pins(1'b1, 1'b1);
        host.pins(1'b1, 1'b0);
        flag(paused, 1'b0);
        host.pins(1'b0, 1'b0);
        flag(paused, 1'b1);
        host.deselect();
        send('{OP_WRITE_DISABLE});
        host.select();
        host.bits(OP_WRITE_ENABLE, 8, rd);
        host.pins(1'b0, 1'b0);
        host.deselect();
        check(device_status, 8'h00);
        read_status(rd, rd2);
        check(rd, 8'h00);
        send('{OP_WRITE_ENABLE});
        send('{OP_STATUS_WRITE, 8'h00});
        host.select();
        host.pins(1'b0, 1'b0);
        host.tick(100);
        flag(device_status[WIP_BIT], 1'b0);
        host.pins(1'b0, 1'b1);
        host.deselect();
        $display("pause test done");
    endtask
    // Long id read: the output buffer keeps the bytes alternating
    task automatic t_stream();
        host.select();
        host.bits(OP_MAKER_PART_ID, 8, rd);
        host.bits(8'h00, 8, rd);
        host.bits(8'h00, 8, rd);
        host.bits(8'h01, 8, rd);
        for (int i = 0; i < 4; i++)
        begin
            host.bits(8'h00, 8, rd);
            host.bits(8'h00, 8, rd2);
            check(rd, PART_ID);
            check(rd2, MAKER_ID);
            flag(so_oe, 1'b1);
        end
        host.deselect();
        flag(so_oe, 1'b0);
        $display("stream test done");
    endtask

    initial
    begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_latch();
        t_status_write();
        t_protect();
        t_ident();
        t_unknown();
        t_pause();
        t_stream();
        test_done();
    end
    // Whole run needs about 0.75 ms; cut a hang well after that
    initial
    begin
        #6000000;
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
endmodule
